// [rtl/reset_state_and_flag_logic.sv]
// Purpose: classify reset sources, keep reset flags, drive initial state
// Assumes: reset requests are one-cycle synchronous pulses on clk
// Notes:   flags and cause are readable over axi4-lite
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps

module reset_state_and_flag_logic
  import reset_state_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  // reset requests and mode inputs
  input  wire logic        power_on_req,        // power-on detected pulse
  input  wire logic        external_clear_pin,  // pin reset pulse
  input  wire logic        undervolt_trigger,   // undervolt reset pulse
  input  wire logic        wdt_overflow,        // watchdog overflow pulse
  input  wire logic        halt_enter,          // core enters idle or sleep
  input  wire logic        wake_up,             // core leaves idle or sleep
  input  wire logic        clrwdt_exec,         // watchdog clear clears flags
  // outputs to core and peripherals
  output reset_kind_t      reset_kind,          // per-source reset strobe
  output init_state_t      init_state,          // values to load on strobe
  output logic             load_pc_sp,          // load pc and sp image
  output logic             load_controls,       // load control image
  output logic             load_watchdog_select,           // load watchdog_select
  output logic             wdt_clear,           // clear watchdog counter
  output logic             prescaler_clear,     // clear timer prescaler
  output logic             timeout_flag,        // status timeout bit
  output logic             powerdown_flag,      // status powerdown bit
  output logic             irq,                 // level interrupt
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ************************************************************
  // reset synchroniser
  // ************************************************************
  logic   rst_meta;    // first stage
  logic   rst_sync_b;  // released copy used everywhere
  // two-stage release
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta   <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta   <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end
  // ************************************************************
  // classification
  // ************************************************************
  logic   idle_mode;   // in idle or sleep
  cause_t next_cause;  // cause seen this cycle
  cause_t last_cause;  // latched cause
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      idle_mode <= 1'b0;
    else if (power_on_req || external_clear_pin || undervolt_trigger || wdt_overflow)
      idle_mode <= 1'b0;   // any reset wakes the core
    else if (halt_enter)
      idle_mode <= 1'b1;
    else if (wake_up)
      idle_mode <= 1'b0;
  end
  always_comb
  begin
    if (power_on_req)
      next_cause = cause_power_on;
    else if (external_clear_pin || undervolt_trigger)
      next_cause = cause_pin;
    else if (wdt_overflow && idle_mode)
      next_cause = cause_wdt_idle;
    else if (wdt_overflow)
      next_cause = cause_wdt_normal;
    else
      next_cause = cause_none;
  end
  // latched cause, readable by software
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      last_cause <= cause_power_on;
    else if (next_cause != cause_none)
      last_cause <= next_cause;
  end
  // ************************************************************
  // reset strobes and initial state
  // ************************************************************
  logic   is_warm;   // pin or normal watchdog reset
  assign is_warm = (next_cause == cause_pin) || (next_cause == cause_wdt_normal);
  // one-cycle strobes per cause
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      reset_kind      <= '0;
      load_pc_sp      <= 1'b0;
      load_controls   <= 1'b0;
      load_watchdog_select       <= 1'b0;
      wdt_clear       <= 1'b0;
      prescaler_clear <= 1'b0;
    end
    else
    begin
      reset_kind.power_on   <= (next_cause == cause_power_on);
      reset_kind.pin        <= (next_cause == cause_pin);
      reset_kind.wdt_normal <= (next_cause == cause_wdt_normal);
      reset_kind.wdt_idle   <= (next_cause == cause_wdt_idle);
      // pc and sp load on every reset
      load_pc_sp      <= (next_cause != cause_none);
      load_controls   <= (next_cause == cause_power_on) || is_warm;
      load_watchdog_select       <= (next_cause == cause_power_on) || is_warm;
      wdt_clear       <= (next_cause != cause_none);
      prescaler_clear <= (next_cause == cause_power_on) || is_warm;
    end
  end
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      init_state <= '{pcl_reset, sp_top, interrupt_control0_reset, timer0_control_reset, port_reset, port_reset,
                      wake_reset, wake_reset, control_one_reset, converter_control_reg_reset, watchdog_select_reset};
    else
    begin
      init_state.sp <= (next_cause == cause_wdt_idle) ? sp_zero : sp_top;
    end
  end
  // ************************************************************
  // status flags and interrupts
  // ************************************************************
  logic [3:0] irq_stat;   // sticky events
  logic [3:0] irq_mask;   // enables
  logic [3:0] events;     // this cycle's events
  logic       wr_fire;    // write taken
  logic [7:0] wr_addr;    // held write address
  logic [31:0] wr_data;   // held write data
  logic       aw_held;    // address captured
  logic       w_held;     // data captured
  assign events = {next_cause == cause_wdt_idle, next_cause == cause_wdt_normal,
                   next_cause == cause_pin, next_cause == cause_power_on};
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  // halt clears timeout and sets powerdown, watchdog clear clears both flags
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      timeout_flag   <= 1'b0;
      powerdown_flag <= 1'b0;
    end
    else
    begin
      case (next_cause)
        cause_power_on:
          {timeout_flag, powerdown_flag} <= 2'b00;
        cause_pin:
          {timeout_flag, powerdown_flag} <= {timeout_flag, powerdown_flag};
        cause_wdt_normal:
          timeout_flag   <= 1'b1;
        cause_wdt_idle:
          {timeout_flag, powerdown_flag} <= 2'b11;
        default:
        begin
          // halt sets powerdown, clears timeout; halt wins over a clear
          if (halt_enter)
            {timeout_flag, powerdown_flag} <= 2'b01;
          else if (clrwdt_exec || (wr_fire && wr_addr == off_ctl
                                   && wr_data[ctl_clr_flags]))
            {timeout_flag, powerdown_flag} <= 2'b00;
        end
      endcase
    end
  end
  // sticky bits, set wins over clear
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      irq_stat <= '0;
    else if (wr_fire && wr_addr == off_irq_stat)
      irq_stat <= (irq_stat & ~wr_data[3:0]) | events;
    else
      irq_stat <= irq_stat | events;
  end
  // mask register
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      irq_mask <= '0;
    else if (wr_fire && wr_addr == off_irq_mask && s_axi_wstrb[0])
      irq_mask <= wr_data[3:0];
  end
  // level interrupt
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_mask);
  end
  // ************************************************************
  // axi4-lite write and read
  // ************************************************************
  // capture address and data in either order, respond once both held
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= '0;
      wr_data       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= resp_okay;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wdata;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr == off_irq_stat || wr_addr == off_irq_mask
                         || wr_addr == off_ctl) ? resp_okay : resp_slverr;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end
  // one read at a time, answer the cycle after arready
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= resp_okay;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= resp_okay;
        case (s_axi_araddr)
          off_cause:    s_axi_rdata <= {29'h0, last_cause};
          off_flags:    s_axi_rdata <= {29'h0, idle_mode, powerdown_flag, timeout_flag};
          off_irq_stat: s_axi_rdata <= {28'h0, irq_stat};
          off_irq_mask: s_axi_rdata <= {28'h0, irq_mask};
          off_ctl:      s_axi_rdata <= 32'h0;
          default:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= resp_slverr;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);
  a_por_clears_flags: assert property (power_on_req |=> !timeout_flag && !powerdown_flag)
    else $error("power-on did not clear flags");
  a_pin_keeps_flags: assert property (!power_on_req && external_clear_pin
      |=> $stable(timeout_flag) && $stable(powerdown_flag))
    else $error("pin reset changed flags");
  a_wdt_norm_flags: assert property (next_cause == cause_wdt_normal
      |=> timeout_flag && $stable(powerdown_flag))
    else $error("normal watchdog flags wrong");
  a_wdt_idle_flags: assert property (next_cause == cause_wdt_idle
      |=> timeout_flag && powerdown_flag)
    else $error("idle watchdog flags wrong");
  a_halt_sets_pdf: assert property (next_cause == cause_none && halt_enter
      |=> powerdown_flag && !timeout_flag)
    else $error("halt did not set powerdown");
  a_idle_keeps_ctl: assert property (next_cause == cause_wdt_idle
      |=> !load_controls && !load_watchdog_select && load_pc_sp && init_state.sp == sp_zero)
    else $error("idle watchdog reloaded controls");
  a_warm_loads_watchdog_select: assert property (is_warm |=> load_watchdog_select && load_controls)
    else $error("warm reset missed reload");
  a_por_priority: assert property (power_on_req && wdt_overflow
      |=> reset_kind.power_on && !reset_kind.wdt_normal && !reset_kind.wdt_idle)
    else $error("power-on lost priority");
  a_idle_tracked: assert property (next_cause == cause_none && halt_enter |=> idle_mode)
    else $error("idle mode not recorded");
  a_irq_level: assert property (##1 irq == $past(|(irq_stat & irq_mask)))
    else $error("irq level wrong");

  c_por:       cover property (reset_kind.power_on);
  c_wdt_idle:  cover property (halt_enter ##[1:20] wdt_overflow);
  c_wdt_norm:  cover property (reset_kind.wdt_normal);
  c_irq:       cover property (irq);

endmodule : reset_state_and_flag_logic

// [shared/reset_state_pkg.sv]
// Purpose: constants and types for the reset state and flag logic
// Assumes: 3- to 8-bit register images, 32-bit axi4-lite data
// Notes:   bus offsets are byte addresses, one aligned word each
package reset_state_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] off_cause     = 8'h00;  // last reset cause, read only
  localparam logic [7:0] off_flags     = 8'h04;  // timeout, powerdown, idle mode
  localparam logic [7:0] off_irq_stat  = 8'h08;  // sticky events, write one clear
  localparam logic [7:0] off_irq_mask  = 8'h0c;  // event enables
  localparam logic [7:0] off_ctl       = 8'h10;  // software control strobes

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int flag_timeout   = 0;  // timeout_flag bit
  localparam int flag_powerdown = 1;  // powerdown_flag bit
  localparam int flag_idle      = 2;  // idle or sleep mode bit
  localparam int ctl_clr_flags  = 0;  // write one clears both flags
  localparam int ev_por         = 0;  // power-on event
  localparam int ev_pin         = 1;  // pin or undervolt event
  localparam int ev_wdt_norm    = 2;  // watchdog normal-mode event
  localparam int ev_wdt_idle    = 3;  // watchdog idle-mode event

  // ************************************************************
  // reset values of the peripheral images
  // ************************************************************
  localparam logic [7:0] pcl_reset      = 8'h00;  // program counter low byte
  localparam logic [2:0] sp_top         = 3'h7;   // top stack level
  localparam logic [2:0] sp_zero        = 3'h0;   // cleared stack pointer
  localparam logic [6:0] interrupt_control0_reset    = 7'h00;  // all interrupts off
  localparam logic [7:0] timer0_control_reset    = 8'h08;  // timer stopped
  localparam logic [7:0] port_reset     = 8'hff;  // latches and directions
  localparam logic [7:0] wake_reset     = 8'h00;  // wake and pull-high
  localparam logic [7:0] control_one_reset    = 8'h8a;  // control_one
  localparam logic [7:0] converter_control_reg_reset     = 8'h40;  // converter_control_reg
  localparam logic [2:0] watchdog_select_reset     = 3'h7;   // watchdog_select
  localparam logic [1:0] resp_okay      = 2'h0;   // axi okay
  localparam logic [1:0] resp_slverr    = 2'h2;   // axi slave error

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0]
  {
    cause_none,
    cause_power_on,
    cause_pin,
    cause_wdt_normal,
    cause_wdt_idle
  } cause_t;

  // per-source reset strobes to the core and peripherals
  typedef struct packed
  {
    logic power_on;   // full initial state
    logic pin;        // pin or undervolt reset
    logic wdt_normal; // watchdog in normal or slow mode
    logic wdt_idle;   // watchdog in idle or sleep
  } reset_kind_t;

  // initial state image handed to the core
  typedef struct packed
  {
    logic [7:0] program_counter_low;
    logic [2:0] sp;
    logic [6:0] interrupt_control0;
    logic [7:0] timer0_control;
    logic [7:0] port_latch;
    logic [7:0] porta_direction;
    logic [7:0] port_a_wake_enable;
    logic [7:0] pull_high;
    logic [7:0] control_one;
    logic [7:0] converter_control_reg;
    logic [2:0] watchdog_select;
  } init_state_t;

endpackage : reset_state_pkg

// [verif/reset_state_and_flag_logic_tb.sv]
// Purpose: self-checking bench for the reset state and flag logic
// Assumes: bench is the axi4-lite master, 20 MHz clock
// Notes:   strobes and flags checked one cycle after a cause pulse
`timescale 1ns/100ps
module reset_state_and_flag_logic_tb
  import reset_state_pkg::*;
;
  // ************************************************************
  // signals
  // ************************************************************
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        power_on_req = 1'b0;
  logic        external_clear_pin = 1'b0;
  logic        undervolt_trigger = 1'b0;
  logic        wdt_overflow = 1'b0;
  logic        halt_enter = 1'b0;
  logic        wake_up = 1'b0;
  logic        clrwdt_exec = 1'b0;
  reset_kind_t reset_kind;
  init_state_t init_state;
  logic        load_pc_sp, load_controls, load_watchdog_select, wdt_clear, prescaler_clear;
  logic        timeout_flag, powerdown_flag, irq;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  int          mismatches = 0;  // failed compares
  int          check_count = 0; // all compares
  int          cycles = 0;      // timeout counter

  // clock, 50 ns period
  always #25 clk = ~clk;

  reset_state_and_flag_logic u_reset_state_and_flag_logic
  (
    .clk(clk), .rst_b(rst_b), .power_on_req(power_on_req),
    .external_clear_pin(external_clear_pin), .undervolt_trigger(undervolt_trigger),
    .wdt_overflow(wdt_overflow), .halt_enter(halt_enter), .wake_up(wake_up),
    .clrwdt_exec(clrwdt_exec), .reset_kind(reset_kind), .init_state(init_state),
    .load_pc_sp(load_pc_sp), .load_controls(load_controls), .load_watchdog_select(load_watchdog_select),
    .wdt_clear(wdt_clear), .prescaler_clear(prescaler_clear),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  // ************************************************************
  // compare tasks and closing report
  // ************************************************************
  task conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word

  task check_image(input init_state_t exp);
    check_count++;
    if (init_state !== exp)
    begin
      mismatches++;
      $display("wrong value init_state expected %h seen %h", exp, init_state);
    end
  endtask : check_image

  // image after a full reset, stack pointer as given
  function automatic init_state_t image_exp(input logic [2:0] sp);
    image_exp = '{8'h00, sp, 7'h00, 8'h08, 8'hff, 8'hff, 8'h00, 8'h00, 8'h8a, 8'h40, 3'h7};
  endfunction : image_exp

  // cut a hang short
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      conclude();
    end
  end

  // ************************************************************
  // drivers
  // ************************************************************
  task axi_write(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
    @(posedge clk);
    s_axi_awaddr <= addr;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= data;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task axi_read(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
    @(posedge clk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  // read one register, compare data and response
  task read_expect(input string name, input logic [7:0] addr, input logic [31:0] exp,
                   input logic [1:0] exp_resp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(addr, d, r);
    check_word(name, exp, d);
    check_word("rresp", {30'h0, exp_resp}, {30'h0, r});
  endtask : read_expect

  // write one register, compare response
  task write_expect(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] exp);
    logic [1:0] r;
    axi_write(addr, data, r);
    check_word("bresp", {30'h0, exp}, {30'h0, r});
  endtask : write_expect

  // one-cycle pulse on {power_on, pin, undervolt, watchdog}
  task fire(input logic [3:0] c);
    @(posedge clk);
    {power_on_req, external_clear_pin, undervolt_trigger, wdt_overflow} <= c;
    @(posedge clk);
    {power_on_req, external_clear_pin, undervolt_trigger, wdt_overflow} <= 4'h0;
    #1;
  endtask : fire

  // one-cycle pulse on {halt, wake, watchdog clear}
  task mode(input logic [2:0] m);
    @(posedge clk);
    {halt_enter, wake_up, clrwdt_exec} <= m;
    @(posedge clk);
    {halt_enter, wake_up, clrwdt_exec} <= 3'h0;
    #1;
  endtask : mode

  // strobes seen one cycle after a cause
  task check_strobes(input logic [3:0] kind, input logic ctl);
    check_word("reset_kind", {28'h0, kind}, {28'h0, reset_kind});
    check_word("load_wdt_pc", 32'h3, {30'h0, load_pc_sp, wdt_clear});
    check_word("load_ctl", {29'h0, {3{ctl}}}, {29'h0, load_controls, load_watchdog_select, prescaler_clear});
  endtask : check_strobes

  task check_flags(input logic to, input logic pd);
    check_word("flags", {30'h0, pd, to}, {30'h0, powerdown_flag, timeout_flag});
  endtask : check_flags

  // ************************************************************
  // scenarios
  // ************************************************************
  task test_reset_state;
    check_flags(1'b0, 1'b0);
    check_image(image_exp(3'h7));
    read_expect("cause", off_cause, 32'h1, resp_okay);
  endtask : test_reset_state

  task test_wdt_normal;
    fire(4'b0001);
    check_strobes(4'b0010, 1'b1);
    check_flags(1'b1, 1'b0);
    read_expect("flags_reg", off_flags, 32'h1, resp_okay);
    read_expect("cause", off_cause, 32'h3, resp_okay);
  endtask : test_wdt_normal

  task test_wdt_idle;
    mode(3'b100);
    check_flags(1'b0, 1'b1);
    read_expect("flags_reg", off_flags, 32'h6, resp_okay);
    fire(4'b0001);
    check_strobes(4'b0001, 1'b0);
    check_word("sp", 32'h0, {29'h0, init_state.sp});
    check_word("pcl", 32'h0, {24'h0, init_state.program_counter_low});
    check_flags(1'b1, 1'b1);
    read_expect("cause", off_cause, 32'h4, resp_okay);
    fire(4'b0001);
    check_strobes(4'b0010, 1'b1);
    check_flags(1'b1, 1'b1);
  endtask : test_wdt_idle

  task test_pin;
    fire(4'b0100);
    check_strobes(4'b0100, 1'b1);
    check_flags(1'b1, 1'b1);
    fire(4'b0010);
    check_strobes(4'b0100, 1'b1);
    check_flags(1'b1, 1'b1);
    read_expect("cause", off_cause, 32'h2, resp_okay);
  endtask : test_pin

  task test_power_on;
    fire(4'b1111);
    check_strobes(4'b1000, 1'b1);
    check_flags(1'b0, 1'b0);
    check_image(image_exp(3'h7));
    read_expect("cause", off_cause, 32'h1, resp_okay);
  endtask : test_power_on

  task test_flag_clear;
    mode(3'b100);
    fire(4'b0001);
    check_flags(1'b1, 1'b1);
    mode(3'b001);
    check_flags(1'b0, 1'b0);
    mode(3'b100);
    write_expect(off_ctl, 32'h1, resp_okay);
    read_expect("flags_reg", off_flags, 32'h4, resp_okay);
    mode(3'b010);
    fire(4'b0001);
    check_strobes(4'b0010, 1'b1);
  endtask : test_flag_clear

  task test_irq;
    write_expect(off_irq_mask, 32'h0, resp_okay);
    write_expect(off_irq_stat, 32'hf, resp_okay);
    fire(4'b0100);
    read_expect("irq_stat", off_irq_stat, 32'h2, resp_okay);
    check_word("irq_masked", 32'h0, {31'h0, irq});
    write_expect(off_irq_mask, 32'h2, resp_okay);
    repeat (3) @(posedge clk);
    #1;
    check_word("irq_on", 32'h1, {31'h0, irq});
    write_expect(off_irq_stat, 32'h2, resp_okay);
    repeat (3) @(posedge clk);
    #1;
    check_word("irq_off", 32'h0, {31'h0, irq});
    read_expect("irq_mask", off_irq_mask, 32'h2, resp_okay);
    read_expect("ctl", off_ctl, 32'h0, resp_okay);
    write_expect(8'h14, 32'h1, resp_slverr);
    read_expect("unmapped", 8'h14, 32'h0, resp_slverr);
  endtask : test_irq

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    test_reset_state();
    test_wdt_normal();
    test_wdt_idle();
    test_pin();
    test_power_on();
    test_flag_clear();
    test_irq();
    conclude();
  end

endmodule : reset_state_and_flag_logic_tb
